/* core/imc_master_command.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_master_command
  import imc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  output var  logic        txReady,
  output var  logic        rxValid,
  output var  logic [7:0]  rxData,
  input  wire logic        rxReady,
  input  wire logic        linkClk,
  input  wire logic        sclIn,
  output var  logic        sclOut,
  output var  logic        sclOe_b,
  input  wire logic        sdaIn,
  output var  logic        sdaOut,
  output var  logic        sdaOe_b
);

  //----------------------------------------------------------
  // System clock side
  //----------------------------------------------------------
  logic [25:0] cmd_q;
  logic        busy_q;
  logic        nack_q;
  logic        cmdTgl_q;
  logic [2:0]  doneSync_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        txReady_q;
  logic        txPutTgl_q;
  logic [7:0]  txHold_q;
  logic [1:0]  txTakeSync_q;
  logic        rxValid_q;
  logic [7:0]  rxData_q;
  logic        rxTakeTgl_q;
  logic [1:0]  rxPutSync_q;

  // Link side registers read across the boundary
  logic        doneTgl_q;
  logic        linkNack_q;
  logic        txTakeTgl_q;
  logic        rxPutTgl_q;
  logic [7:0]  rxHold_q;

  // Bus decode
  wire logic apbAccess = psel && penable && !pready_q;
  wire logic apbDone   = psel && penable && pready_q;
  wire logic hitCmd    = paddr == IMC_CMD_OFFSET;
  wire logic hitStat   = paddr == IMC_STAT_OFFSET;
  wire logic cmdWrite  = apbDone && pwrite && hitCmd;
  wire logic cmdLaunch = cmdWrite && !busy_q;
  wire logic doneSeen  = doneSync_q[1] != doneSync_q[2];
  wire logic [31:0] statWord = {30'h0, nack_q, busy_q};
  wire logic [31:0] readWord = hitCmd ? {6'h00, cmd_q} : (hitStat ? statWord : 32'h00000000);

  // Byte stream decode
  wire logic txAccept  = txValid && txReady_q;
  wire logic txPutNext = txPutTgl_q ^ txAccept;
  wire logic rxPending = rxPutSync_q[1] != rxTakeTgl_q;
  wire logic rxLoad    = rxPending && (!rxValid_q || rxReady);

  // Slave answer one cycle into the access phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= apbAccess;
      pslverr_q <= apbAccess && !(hitCmd || hitStat);
      if (apbAccess && !pwrite) begin
        prdata_q <= readWord;
      end
    end
  end

  // Command register, busy and outcome
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q      <= IMC_CMD_RESET;
      busy_q     <= 1'b0;
      nack_q     <= 1'b0;
      cmdTgl_q   <= 1'b0;
      doneSync_q <= 3'h0;
    end else begin
      doneSync_q <= {doneSync_q[1:0], doneTgl_q};
      if (cmdLaunch) begin
        cmd_q    <= pwdata[25:0];
        cmdTgl_q <= !cmdTgl_q;
        busy_q   <= 1'b1;
        nack_q   <= 1'b0;
      end else if (doneSeen) begin
        busy_q   <= 1'b0;
        nack_q   <= linkNack_q;
      end
    end
  end

  // Transmit byte hand-over into the link domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txReady_q    <= 1'b0;
      txPutTgl_q   <= 1'b0;
      txHold_q     <= 8'h00;
      txTakeSync_q <= 2'h0;
    end else begin
      txTakeSync_q <= {txTakeSync_q[0], txTakeTgl_q};
      txPutTgl_q   <= txPutNext;
      txReady_q    <= txPutNext == txTakeSync_q[1];
      if (txAccept) begin
        txHold_q <= txData;
      end
    end
  end

  // Receive byte hand-over out of the link domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxValid_q   <= 1'b0;
      rxData_q    <= 8'h00;
      rxTakeTgl_q <= 1'b0;
      rxPutSync_q <= 2'h0;
    end else begin
      rxPutSync_q <= {rxPutSync_q[0], rxPutTgl_q};
      if (rxLoad) begin
        rxData_q    <= rxHold_q;
        rxValid_q   <= 1'b1;
        rxTakeTgl_q <= !rxTakeTgl_q;
      end else if (rxReady) begin
        rxValid_q <= 1'b0;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign txReady = txReady_q;
  assign rxValid = rxValid_q;
  assign rxData  = rxData_q;

  //----------------------------------------------------------
  // Link clock side
  //----------------------------------------------------------
  logic [1:0]  linkRst_q;
  logic [2:0]  cmdSync_q;
  logic [1:0]  txPutSync_q;
  logic [1:0]  rxTakeSync_q;
  logic [1:0]  sclSync_q;
  logic [1:0]  sdaSync_q;
  imc_state_t  state_q;
  imc_state_t  state_d;
  imc_step_t   step_q;
  imc_step_t   step_d;
  logic [7:0]  qCnt_q;
  logic [1:0]  phase_q;
  logic [2:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic        ackBit_q;
  logic        cmdPend_q;
  logic        cDir_q;
  logic [6:0]  cAddrLo_q;
  logic [2:0]  cAddrHi_q;
  logic        cSb_q;
  logic [1:0]  cType_q;
  logic        cStop_q;
  logic [10:0] remain_q;
  logic        sclOe_b_q;
  logic        sdaOe_b_q;
  logic        sclOut_q;
  logic        sdaOut_q;
  logic        sclLow;
  logic        sdaLow;
  logic        nackHit;

  wire logic linkRstB = linkRst_q[1];

  // Reset release aligned to the link clock
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRst_q <= 2'h0;
    end else begin
      linkRst_q <= {linkRst_q[0], 1'b1};
    end
  end

  // Link decode
  wire logic cmdEdge  = cmdSync_q[1] != cmdSync_q[2];
  wire logic txAvail  = txPutSync_q[1] != txTakeTgl_q;
  wire logic rxSpace  = rxPutTgl_q == rxTakeSync_q[1];
  wire logic stretch  = (phase_q == 2'h1) && !sclSync_q[1];
  wire logic tick     = (qCnt_q == IMC_QUARTER_LAST) && !stretch;
  wire logic lastQ    = tick && (phase_q == 2'h3);
  wire logic lastBit  = lastQ && (bitCnt_q == 3'h7);
  wire logic lenDone  = remain_q == 11'h000;
  wire logic tenBit   = cType_q == IMC_TYPE_10;
  wire logic readOp   = cDir_q && (cType_q != IMC_TYPE_GCALL);
  wire logic [9:0] addr10 = {cAddrHi_q, cAddrLo_q};
  wire logic [7:0] tenHead = {IMC_TEN_TAG, addr10[9:8], 1'b0};
  wire logic [7:0] firstByte = (cType_q == IMC_TYPE_GCALL) ? IMC_GCALL_BYTE :
                               (tenBit ? tenHead : {cAddrLo_q, cDir_q});
  wire logic [7:0] rdHead = {IMC_TEN_TAG, addr10[9:8], 1'b1};
  wire logic [7:0] loadByte = (step_d == SP_PREFIX) ? IMC_START_BYTE :
                              (step_d == SP_ADDR1) ? firstByte :
                              (step_d == SP_ADDR2) ? addr10[7:0] :
                              (step_d == SP_ADDR_RD) ? rdHead : txHold_q;
  wire logic load     = (state_d == ST_XBYTE) && (state_q != ST_XBYTE);
  wire logic dataLoad = load && (step_d == SP_DATA);
  wire logic rdEnter  = (state_d == ST_RBYTE) && (state_q != ST_RBYTE);
  wire logic finish   = ((state_q == ST_STOP) && (state_d == ST_IDLE)) ||
                        ((state_d == ST_PARK) && (state_q != ST_PARK));
  wire logic launch   = (state_d == ST_START) &&
                        ((state_q == ST_IDLE) || (state_q == ST_PARK));
  wire imc_state_t endState  = cStop_q ? ST_STOP : ST_PARK;
  wire imc_state_t readState = rxSpace ? ST_RBYTE : ST_WAITRX;
  wire imc_state_t writState = txAvail ? ST_XBYTE : ST_WAITTX;
  wire imc_state_t dataState = lenDone ? endState : (readOp ? readState : writState);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    nackHit = 1'b0;
    unique case (state_q)
      ST_IDLE, ST_PARK: begin
        if (cmdPend_q && (readOp || lenDone || txAvail)) begin
          state_d = ST_START;
          step_d  = cSb_q ? SP_PREFIX : SP_ADDR1;
        end
      end
      ST_START: if (lastQ) state_d = ST_XBYTE;
      ST_XBYTE: if (lastBit) state_d = ST_XACK;
      ST_XACK: begin
        if (lastQ) begin
          if (step_q == SP_PREFIX) begin
            state_d = ST_START;
            step_d  = SP_ADDR1;
          end else if (ackBit_q) begin
            nackHit = 1'b1;
            state_d = ST_STOP;
          end else if ((step_q == SP_ADDR1) && tenBit) begin
            state_d = ST_XBYTE;
            step_d  = SP_ADDR2;
          end else if ((step_q == SP_ADDR2) && readOp) begin
            state_d = ST_START;
            step_d  = SP_ADDR_RD;
          end else begin
            state_d = dataState;
            step_d  = SP_DATA;
          end
        end
      end
      ST_RBYTE: if (lastBit) state_d = ST_RACK;
      ST_RACK: if (lastQ) state_d = dataState;
      ST_WAITTX, ST_WAITRX: state_d = dataState;
      ST_STOP: if (lastQ) state_d = ST_IDLE;
    endcase
  end

  // Line drive per state and quarter
  always_comb begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
      end
      ST_PARK, ST_WAITTX, ST_WAITRX: sclLow = 1'b1;
      ST_START: begin
        sclLow = (phase_q == 2'h0) ? !sclOe_b_q : (phase_q == 2'h3);
        sdaLow = phase_q[1];
      end
      ST_XBYTE: begin
        sclLow = (phase_q == 2'h0) || (phase_q == 2'h3);
        sdaLow = !shift_q[7];
      end
      ST_XACK, ST_RBYTE: sclLow = (phase_q == 2'h0) || (phase_q == 2'h3);
      ST_RACK: begin
        sclLow = (phase_q == 2'h0) || (phase_q == 2'h3);
        sdaLow = !lenDone;
      end
      ST_STOP: begin
        sclLow = phase_q == 2'h0;
        sdaLow = !phase_q[1];
      end
    endcase
  end

  // Crossing and pin synchronisers
  always_ff @(posedge linkClk or negedge linkRstB) begin
    if (!linkRstB) begin
      cmdSync_q    <= 3'h0;
      txPutSync_q  <= 2'h0;
      rxTakeSync_q <= 2'h0;
      sclSync_q    <= 2'h3;
      sdaSync_q    <= 2'h3;
    end else begin
      cmdSync_q    <= {cmdSync_q[1:0], cmdTgl_q};
      txPutSync_q  <= {txPutSync_q[0], txPutTgl_q};
      rxTakeSync_q <= {rxTakeSync_q[0], rxTakeTgl_q};
      sclSync_q    <= {sclSync_q[0], sclIn};
      sdaSync_q    <= {sdaSync_q[0], sdaIn};
    end
  end

  // Command capture at the launch toggle
  always_ff @(posedge linkClk or negedge linkRstB) begin
    if (!linkRstB) begin
      cmdPend_q <= 1'b0;
      cDir_q    <= 1'b0;
      cAddrLo_q <= 7'h00;
      cAddrHi_q <= 3'h0;
      cSb_q     <= 1'b0;
      cType_q   <= 2'h0;
      cStop_q   <= 1'b0;
    end else if (cmdEdge) begin
      cmdPend_q <= 1'b1;
      cDir_q    <= cmd_q[IMC_DIR_POS];
      cAddrLo_q <= cmd_q[IMC_ALO_MSB:IMC_ALO_LSB];
      cAddrHi_q <= cmd_q[IMC_AHI_MSB:IMC_AHI_LSB];
      cSb_q     <= cmd_q[IMC_SB_POS];
      cType_q   <= cmd_q[IMC_TYPE_MSB:IMC_TYPE_LSB];
      cStop_q   <= cmd_q[IMC_STOP_POS];
    end else if (launch) begin
      cmdPend_q <= 1'b0;
    end
  end

  // Sequencer, timing and byte shifting
  always_ff @(posedge linkClk or negedge linkRstB) begin
    if (!linkRstB) begin
      state_q  <= ST_IDLE;
      step_q   <= SP_ADDR1;
      qCnt_q   <= 8'h00;
      phase_q  <= 2'h0;
      bitCnt_q <= 3'h0;
      shift_q  <= 8'h00;
      ackBit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      if (state_d != state_q) begin
        qCnt_q   <= 8'h00;
        phase_q  <= 2'h0;
        bitCnt_q <= 3'h0;
      end else if (tick) begin
        qCnt_q   <= 8'h00;
        phase_q  <= phase_q + 2'h1;
        bitCnt_q <= bitCnt_q + {2'h0, phase_q == 2'h3};
      end else if (qCnt_q != IMC_QUARTER_LAST) begin
        qCnt_q <= qCnt_q + 8'h01;
      end
      if (load) begin
        shift_q <= loadByte;
      end else if (tick && (state_q == ST_XBYTE) && (phase_q == 2'h3)) begin
        shift_q <= {shift_q[6:0], 1'b0};
      end else if (tick && (state_q == ST_RBYTE) && (phase_q == 2'h2)) begin
        shift_q <= {shift_q[6:0], sdaSync_q[1]};
      end
      if (tick && (state_q == ST_XACK) && (phase_q == 2'h2)) begin
        ackBit_q <= sdaSync_q[1];
      end
    end
  end

  // Byte count, hand-over toggles and pins
  always_ff @(posedge linkClk or negedge linkRstB) begin
    if (!linkRstB) begin
      remain_q    <= 11'h000;
      txTakeTgl_q <= 1'b0;
      rxPutTgl_q  <= 1'b0;
      rxHold_q    <= 8'h00;
      doneTgl_q   <= 1'b0;
      linkNack_q  <= 1'b0;
      sclOe_b_q   <= 1'b1;
      sdaOe_b_q   <= 1'b1;
      sclOut_q    <= 1'b0;
      sdaOut_q    <= 1'b0;
    end else begin
      sclOe_b_q <= !sclLow;
      sdaOe_b_q <= !sdaLow;
      if (cmdEdge) begin
        remain_q   <= cmd_q[IMC_LEN_MSB:IMC_LEN_LSB];
        linkNack_q <= 1'b0;
      end else if (dataLoad || rdEnter) begin
        remain_q <= remain_q - 11'h001;
      end
      if (nackHit) begin
        linkNack_q <= 1'b1;
      end
      if (dataLoad) begin
        txTakeTgl_q <= !txTakeTgl_q;
      end
      if ((state_q == ST_RBYTE) && (state_d == ST_RACK)) begin
        rxHold_q   <= shift_q;
        rxPutTgl_q <= !rxPutTgl_q;
      end
      if (finish) begin
        doneTgl_q <= !doneTgl_q;
      end
    end
  end

  assign sclOut  = sclOut_q;
  assign sdaOut  = sdaOut_q;
  assign sclOe_b = sclOe_b_q;
  assign sdaOe_b = sdaOe_b_q;

  //----------------------------------------------------------
  // Checks
  //----------------------------------------------------------
  property p_read_dir;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_RBYTE) |-> cDir_q && (cType_q != IMC_TYPE_GCALL);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read without read direction");

  property p_addr7;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_XBYTE) && (step_q == SP_ADDR1) && (cType_q == IMC_TYPE_7)
      |-> shift_q == {cAddrLo_q, cDir_q} ##1 sdaOe_b_q == cAddrLo_q[6];
  endproperty
  a_addr7: assert property (p_addr7) else $error("7-bit address byte wrong");

  property p_addr10;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_XBYTE) && (step_q == SP_ADDR2)
      |-> tenBit && (shift_q == {cAddrHi_q[0], cAddrLo_q});
  endproperty
  a_addr10: assert property (p_addr10) else $error("10-bit second byte wrong");

  property p_prefix;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_XBYTE) && (step_q == SP_PREFIX) |-> cSb_q && (shift_q == IMC_START_BYTE);
  endproperty
  a_prefix: assert property (p_prefix) else $error("start byte sent wrongly");

  property p_gcall;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_XBYTE) && (step_q == SP_ADDR1) && (cType_q == IMC_TYPE_GCALL)
      |-> shift_q == IMC_GCALL_BYTE;
  endproperty
  a_gcall: assert property (p_gcall) else $error("general call byte wrong");

  property p_park;
    @(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_PARK) |-> !cStop_q ##1 !sclOe_b_q;
  endproperty
  a_park: assert property (p_park) else $error("bus parked despite stop request");

  property p_count;
    @(posedge linkClk) disable iff (!linkRstB)
    (dataLoad || rdEnter) |-> !lenDone;
  endproperty
  a_count: assert property (p_count) else $error("byte beyond programmed length");

  property p_last_nack;
    @(posedge linkClk) disable iff (!linkRstB)
    (state_q == ST_RACK) && (phase_q == 2'h1) |-> sdaOe_b_q == lenDone;
  endproperty
  a_last_nack: assert property (p_last_nack) else $error("read ack/nack wrong");

  property p_refill;
    @(posedge linkClk) disable iff (!linkRstB)
    (state_q == ST_WAITTX) && txAvail |=> state_q == ST_XBYTE;
  endproperty
  a_refill: assert property (p_refill) else $error("write did not resume");

  property p_rx_hold;
    @(posedge linkClk) disable iff (!linkRstB)
    (state_q == ST_WAITRX) [*2] |-> !sclOe_b_q;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("clock released while full");

  property p_launch;
    @(posedge sys_clk) disable iff (!rst_b)
    cmdWrite |=> (cmd_q == ($past(busy_q) ? $past(cmd_q) : $past(pwdata[25:0])))
      && ($past(busy_q) || busy_q);
  endproperty
  a_launch: assert property (p_launch) else $error("command write mishandled");

  c_read_nack: cover property (@(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_RACK) && lenDone);
  c_ten_bit: cover property (@(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_XBYTE) && (step_q == SP_ADDR_RD));
  c_parked: cover property (@(posedge linkClk) disable iff (!linkRstB)
    $rose(state_q == ST_PARK));

endmodule : imc_master_command
`default_nettype wire

/* core/imc_pkg.sv */
//------------------------------------------------------------
//------------------------------------------------------------
package imc_pkg;

  // Register offsets and reset values
  localparam logic [11:0] IMC_CMD_OFFSET   = 12'h00C;
  localparam logic [11:0] IMC_STAT_OFFSET  = 12'h020;
  localparam logic [25:0] IMC_CMD_RESET    = 26'h0000000;

  // Command field positions
  localparam int IMC_DIR_POS   = 0;
  localparam int IMC_ALO_LSB   = 1;
  localparam int IMC_ALO_MSB   = 7;
  localparam int IMC_AHI_LSB   = 8;
  localparam int IMC_AHI_MSB   = 10;
  localparam int IMC_SB_POS    = 11;
  localparam int IMC_TYPE_LSB  = 12;
  localparam int IMC_TYPE_MSB  = 13;
  localparam int IMC_STOP_POS  = 14;
  localparam int IMC_LEN_LSB   = 15;
  localparam int IMC_LEN_MSB   = 25;

  // Status field positions
  localparam int IMC_STAT_BUSY_POS = 0;
  localparam int IMC_STAT_NACK_POS = 1;

  // Address type codes
  localparam logic [1:0] IMC_TYPE_GCALL = 2'h0;
  localparam logic [1:0] IMC_TYPE_7     = 2'h1;
  localparam logic [1:0] IMC_TYPE_10    = 2'h2;

  // Fixed bus bytes
  localparam logic [7:0] IMC_START_BYTE = 8'h01;
  localparam logic [7:0] IMC_GCALL_BYTE = 8'h00;
  localparam logic [4:0] IMC_TEN_TAG    = 5'h1E;

  // Serial bit timing on the link clock
  localparam int         IMC_BIT_TIME_NS    = 10000;
  localparam int         IMC_LINK_PERIOD_NS = 15;
  localparam int         IMC_QUARTER_CYC    = IMC_BIT_TIME_NS / (4 * IMC_LINK_PERIOD_NS);
  localparam logic [7:0] IMC_QUARTER_LAST   = 8'(IMC_QUARTER_CYC - 1);

  // Bus sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_START  = 4'h1,
    ST_XBYTE  = 4'h2,
    ST_XACK   = 4'h3,
    ST_RBYTE  = 4'h4,
    ST_RACK   = 4'h5,
    ST_STOP   = 4'h6,
    ST_PARK   = 4'h7,
    ST_WAITTX = 4'h8,
    ST_WAITRX = 4'h9
  } imc_state_t;

  // Byte being handled within a transfer
  typedef enum logic [2:0] {
    SP_PREFIX  = 3'h0,
    SP_ADDR1   = 3'h1,
    SP_ADDR2   = 3'h2,
    SP_ADDR_RD = 3'h3,
    SP_DATA    = 3'h4
  } imc_step_t;

endpackage : imc_pkg

/* tb/imc_master_command_test.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_master_command_test;
  import imc_pkg::*;
  localparam int LIMIT = 99000;
  logic        sys_clk, linkClk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        txValid, txReady, rxValid, rxReady;
  logic [7:0]  txData, rxData;
  logic        sclOut, sclOe_b, sdaOut, sdaOe_b, sclLow, sdaLow;
  logic [7:0]  expB[9] = '{8'hF2, 8'h35, 8'hC3, 8'h01, 8'h00, 8'h43, 8'hA0, 8'hA1, 8'hA2};
  int          errCount, compares, cycles, hiCount;
  wire         sclIn = (sclOe_b | sclOut) & ~sclLow;
  wire         sdaIn = (sdaOe_b | sdaOut) & ~sdaLow;

  imc_master_command dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txValid(txValid), .txData(txData), .txReady(txReady), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .linkClk(linkClk), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe_b(sclOe_b), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b));
  imc_slave_model slv (.scl(sclIn), .sda(sdaIn), .sclLow(sclLow), .sdaLow(sdaLow));

  //----------------------------
  // Clocks, timeout, helpers
  //----------------------------
  always #5 sys_clk = ~sys_clk;
  always #7.5 linkClk = ~linkClk;
  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errCount++;
      testDone;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task waitIdle;
    rd = 32'h1;
    while (rd[IMC_STAT_BUSY_POS] !== 1'b0) apb(1'b0, IMC_STAT_OFFSET, 32'h0);
  endtask : waitIdle
  task testDone;
    $display("mismatches %0d, comparisons %0d", errCount, compares);
    if (errCount == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : testDone

  // Main sequence
  initial begin
    {sys_clk, linkClk, rst_b, psel, penable, pwrite, txValid, rxReady} = '0;
    {paddr, pwdata, txData, errCount, compares, cycles} = '0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, IMC_CMD_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    repeat (4) @(posedge linkClk);
    apb(1'b1, IMC_CMD_OFFSET, 32'h0000E26A);
    repeat (2000) @(posedge sys_clk);
    chk({31'h0, sdaOe_b}, 32'h1);
    txData <= 8'hC3;
    txValid <= 1'b1;
    do @(posedge sys_clk); while (txReady !== 1'b1);
    txValid <= 1'b0;
    wait (sdaOe_b === 1'b0);
    apb(1'b1, IMC_CMD_OFFSET, 32'h0);
    apb(1'b0, IMC_CMD_OFFSET, 32'h0);
    chk(rd, 32'h0000E26A);
    waitIdle;
    chk(rd, 32'h0);
    apb(1'b1, IMC_CMD_OFFSET, 32'h000008FF);
    wait (sdaOe_b === 1'b0);
    waitIdle;
    chk({31'h0, sclOe_b}, 32'h0);
    apb(1'b1, IMC_CMD_OFFSET, 32'h0001D043);
    // Two bytes fill both holds; the third must wait with the clock low
    do @(posedge sys_clk); while (slv.got.size() < 8);
    repeat (1500) @(posedge sys_clk);
    hiCount = 0;
    repeat (1000) begin
      @(posedge sys_clk);
      if (sclOe_b !== 1'b0) hiCount++;
    end
    chk(hiCount, 0);
    chk(slv.got.size(), 8);
    chk({31'h0, rxValid}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      do @(posedge sys_clk); while (rxValid !== 1'b1);
      rxReady <= 1'b1;
      chk({24'h0, rxData}, 32'hA0 + 32'(i));
      @(posedge sys_clk);
      rxReady <= 1'b0;
    end
    waitIdle;
    chk({29'h0, slv.masterAck[0], slv.masterAck[1], slv.masterAck[2]}, 32'h1);
    chk({30'h0, sclOe_b, sdaOe_b}, 32'h3);
    chk(slv.got.size(), 9);
    foreach (expB[i]) chk({24'h0, slv.got[i]}, {24'h0, expB[i]});
    testDone;
  end
endmodule : imc_master_command_test
`default_nettype wire

/* tb/imc_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_slave_model #(
  parameter int STRETCH_NS = 2000
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sclLow,
  output var  logic sdaLow
);
  logic [7:0] shiftQ;
  logic [7:0] rdByte;
  logic       rdMode;
  logic       addrPhase;
  logic       mNack;
  int         bitCnt;
  logic [7:0] got[$];
  logic       masterAck[$];

  //----------------------------
  // Bus target
  //----------------------------
  // Idle, lines released
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    bitCnt = 0;
    rdMode = 1'b0;
  end
  // Start or repeated start restarts framing
  always @(negedge sda) begin
    if (scl) begin
      bitCnt = -1; // Start's own clock fall lands on bit zero
      addrPhase = 1'b1;
      rdMode = 1'b0;
      mNack = 1'b0;
      rdByte = 8'hA0;
      sdaLow = 1'b0;
    end
  end
  // Sample data, or the master's answer on reads
  always @(posedge scl) begin
    if (bitCnt < 8) shiftQ = {shiftQ[6:0], sda};
    else if (rdMode) begin
      mNack = sda;
      masterAck.push_back(sda);
    end
  end
  // Drive after falling clock, stretch after each answer
  always @(negedge scl) begin
    if (bitCnt == 7) begin
      got.push_back(shiftQ);
      sdaLow = !rdMode && shiftQ != 8'h01; // No answer to the start byte
      bitCnt = 8;
    end else if (bitCnt == 8) begin
      if (addrPhase && shiftQ != 8'h01) begin
        rdMode = shiftQ[0];
        addrPhase = 1'b0;
      end else if (rdMode) rdByte = rdByte + 8'h01;
      bitCnt = 0;
      sdaLow = rdMode && !mNack && !rdByte[7];
      sclLow = 1'b1;
      #STRETCH_NS;
      sclLow = 1'b0;
    end else begin
      bitCnt++;
      sdaLow = rdMode && !mNack && !rdByte[7-bitCnt];
    end
  end
endmodule : imc_slave_model
`default_nettype wire
